// File: verilog/psd_consts.vh
// constants for the processor-status and debug register bank
// assumes registers are reached by number through the status access port
`ifndef PSD_CONSTS_VH
`define PSD_CONSTS_VH

`define PSD_ADDR_W 8
`define PSD_REG_OSC_CTRL 8'h06
`define PSD_REG_OSC_CNT0 8'h07
`define PSD_REG_OSC_CNT1 8'h08
`define PSD_REG_OSC_CNT2 8'h09
`define PSD_REG_OSC_CNT3 8'h0a
`define PSD_REG_MEM_SIZE 8'h0c
`define PSD_REG_SV_STATUS 8'h10
`define PSD_REG_SV_PC 8'h11
`define PSD_REG_SV_SP 8'h12
`define PSD_REG_RD_THREAD 8'h13
`define PSD_REG_RD_REG 8'h14
`define PSD_REG_CAUSE 8'h15
`define PSD_REG_INFO 8'h16
`define PSD_REG_HOLD 8'h18

`define PSD_OSC_CORE_BIT 1
`define PSD_OSC_PERIPH_BIT 0
`define PSD_OSC_CTRL_RESET 2'h0
`define PSD_OSC_CNT_W 16

`define PSD_MEM_SIZE_BYTES 32'h00040000

`define PSD_STATUS_W 11
`define PSD_STATUS_WR_MASK 11'h6df
`define PSD_STATUS_ISSUE_BIT 8

`define PSD_CAUSE_NONE 3'h0
`define PSD_CAUSE_HOST 3'h1
`define PSD_CAUSE_CALL 3'h2
`define PSD_CAUSE_IBRK 3'h3
`define PSD_CAUSE_DWATCH 3'h4
`define PSD_CAUSE_RWATCH 3'h5
`define PSD_CAUSE_CODE_LSB 0
`define PSD_CAUSE_THREAD_LSB 8
`define PSD_CAUSE_BP_LSB 16

`define PSD_THREAD_W 8
`define PSD_REGNUM_W 5

`endif

// File: verilog/psd_regs.v
// processor-status register bank: ring oscillator counters, memory size,
// debug entry capture, debug register-read operands and thread hold mask.
// assumes the core issues one status access at a time and raises dbgMode
// while the debugger runs; oscillator outputs arrive on pins unsynchronised.
`timescale 1ns/1ps
`include "psd_consts.vh"

// one oscillator pin: three-flop crossing, edge detect and a counter
// that only power-up clears, so a system reset keeps the count
module psd_osc_counter
#(
  parameter CNT_W = 16
)
(
  input wire sys_clk,
  input wire porRstn,
  input wire oscPin,
  input wire runEn,
  output reg [CNT_W-1:0] count_ff
);

  reg [2:0] sync_ff;
  reg level_ff;
  wire agreed;
  wire rise;

  // a rising edge counts once the second and third stages agree on the new level
  assign agreed = (sync_ff[1] == sync_ff[2]);
  assign rise = agreed & sync_ff[2] & ~level_ff;

  always @(posedge sys_clk or negedge porRstn)
  begin
    if (!porRstn)
    begin
      sync_ff <= 3'h0;
      level_ff <= 1'b0;
      count_ff <= {CNT_W{1'b0}};
    end
    else
    begin
      sync_ff <= {sync_ff[1:0], oscPin};
      if (agreed)
      begin
        level_ff <= sync_ff[2];
      end
      if (rise & runEn)
      begin
        count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

module psd_regs
(
  input wire sys_clk,
  input wire rstn,
  input wire porRstn,
  input wire psWrEn,
  input wire psRdEn,
  input wire [7:0] psAddr,
  input wire [31:0] psWrData,
  input wire dbgMode,
  input wire [3:0] oscIn,
  input wire dbgEntry,
  input wire [10:0] entryStatus,
  input wire [31:0] entryPc,
  input wire [31:0] entrySp,
  input wire [2:0] entryCause,
  input wire [7:0] entryThread,
  input wire [3:0] entryHits,
  input wire [31:0] entryInfo,
  output reg [31:0] psRdData_ff,
  output reg psRdValid_ff,
  output reg oscCoreEn_ff,
  output reg oscPeriphEn_ff,
  output reg [7:0] rdThreadOut_ff,
  output reg [4:0] rdRegOut_ff,
  output reg [7:0] threadHold_ff
);

  reg [1:0] oscCtrl_ff;
  reg [10:0] svStatus_ff;
  reg [31:0] svPc_ff;
  reg [31:0] svSp_ff;
  reg [7:0] rdThread_ff;
  reg [4:0] rdReg_ff;
  reg [2:0] causeCode_ff;
  reg [7:0] causeThread_ff;
  reg [1:0] causeBp_ff;
  reg [31:0] info_ff;
  reg [7:0] holdMask_ff;
  wire [`PSD_OSC_CNT_W*4-1:0] oscCount;
  reg [31:0] nxt_rdData;
  reg [1:0] hitNum;
  reg [1:0] bpNum;
  reg [7:0] thrNum;
  reg [31:0] infoVal;

  wire dbgWr = psWrEn & dbgMode;

  // tile pair runs on the core enable, peripheral pair on the peripheral enable
  psd_osc_counter #(.CNT_W(`PSD_OSC_CNT_W)) u_tileCell
  (
    .sys_clk(sys_clk),
    .porRstn(porRstn),
    .oscPin(oscIn[0]),
    .runEn(oscCtrl_ff[`PSD_OSC_CORE_BIT]),
    .count_ff(oscCount[15:0])
  );

  psd_osc_counter #(.CNT_W(`PSD_OSC_CNT_W)) u_tileWire
  (
    .sys_clk(sys_clk),
    .porRstn(porRstn),
    .oscPin(oscIn[1]),
    .runEn(oscCtrl_ff[`PSD_OSC_CORE_BIT]),
    .count_ff(oscCount[31:16])
  );

  psd_osc_counter #(.CNT_W(`PSD_OSC_CNT_W)) u_periphCell
  (
    .sys_clk(sys_clk),
    .porRstn(porRstn),
    .oscPin(oscIn[2]),
    .runEn(oscCtrl_ff[`PSD_OSC_PERIPH_BIT]),
    .count_ff(oscCount[47:32])
  );

  psd_osc_counter #(.CNT_W(`PSD_OSC_CNT_W)) u_periphWire
  (
    .sys_clk(sys_clk),
    .porRstn(porRstn),
    .oscPin(oscIn[3]),
    .runEn(oscCtrl_ff[`PSD_OSC_PERIPH_BIT]),
    .count_ff(oscCount[63:48])
  );

  // lowest numbered hit wins when several trigger together
  always @*
  begin
    hitNum = 2'h0;
    if (entryHits[0])
    begin
      hitNum = 2'h0;
    end
    else if (entryHits[1])
    begin
      hitNum = 2'h1;
    end
    else if (entryHits[2])
    begin
      hitNum = 2'h2;
    end
    else if (entryHits[3])
    begin
      hitNum = 2'h3;
    end
    bpNum = hitNum;
    if (entryCause == `PSD_CAUSE_HOST || entryCause == `PSD_CAUSE_CALL)
    begin
      bpNum = 2'h0;
    end
    thrNum = entryThread;
    if (entryCause == `PSD_CAUSE_HOST)
    begin
      thrNum = 8'h00;
    end
    infoVal = 32'h00000000;
    if (entryCause == `PSD_CAUSE_DWATCH || entryCause == `PSD_CAUSE_RWATCH)
    begin
      infoVal = entryInfo;
    end
  end

  // oscillator control is writable outside debug mode too
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      oscCtrl_ff <= `PSD_OSC_CTRL_RESET;
      oscCoreEn_ff <= 1'b0;
      oscPeriphEn_ff <= 1'b0;
    end
    else
    begin
      if (psWrEn && psAddr == `PSD_REG_OSC_CTRL)
      begin
        oscCtrl_ff <= psWrData[1:0];
      end
      oscCoreEn_ff <= oscCtrl_ff[`PSD_OSC_CORE_BIT];
      oscPeriphEn_ff <= oscCtrl_ff[`PSD_OSC_PERIPH_BIT];
    end
  end

  // debug registers: entry capture beats a same-cycle software write
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      svStatus_ff <= 11'h000;
      svPc_ff <= 32'h00000000;
      svSp_ff <= 32'h00000000;
      causeCode_ff <= `PSD_CAUSE_NONE;
      causeThread_ff <= 8'h00;
      causeBp_ff <= 2'h0;
      info_ff <= 32'h00000000;
    end
    else if (dbgEntry)
    begin
      svStatus_ff <= entryStatus & 11'h7df;
      svPc_ff <= entryPc;
      svSp_ff <= entrySp;
      causeCode_ff <= entryCause;
      causeThread_ff <= thrNum;
      causeBp_ff <= bpNum;
      info_ff <= infoVal;
    end
    else if (dbgWr)
    begin
      case (psAddr)
        `PSD_REG_SV_STATUS:
        begin
          // issue-mode bit 8 keeps the captured value
          svStatus_ff <= (svStatus_ff & ~`PSD_STATUS_WR_MASK) |
            (psWrData[10:0] & `PSD_STATUS_WR_MASK);
        end
        `PSD_REG_SV_PC:
        begin
          svPc_ff <= psWrData;
        end
        `PSD_REG_SV_SP:
        begin
          svSp_ff <= psWrData;
        end
        `PSD_REG_CAUSE:
        begin
          causeCode_ff <= psWrData[2:0];
          causeThread_ff <= psWrData[15:8];
          causeBp_ff <= psWrData[17:16];
        end
        `PSD_REG_INFO:
        begin
          info_ff <= psWrData;
        end
        default:
        begin
          info_ff <= info_ff;
        end
      endcase
    end
  end

  // operands and hold mask are debugger-written only
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdThread_ff <= 8'h00;
      rdReg_ff <= 5'h00;
      holdMask_ff <= 8'h00;
      rdThreadOut_ff <= 8'h00;
      rdRegOut_ff <= 5'h00;
      threadHold_ff <= 8'h00;
    end
    else
    begin
      if (dbgWr && psAddr == `PSD_REG_RD_THREAD)
      begin
        rdThread_ff <= psWrData[7:0];
      end
      if (dbgWr && psAddr == `PSD_REG_RD_REG)
      begin
        rdReg_ff <= psWrData[4:0];
      end
      if (dbgWr && psAddr == `PSD_REG_HOLD)
      begin
        holdMask_ff <= psWrData[7:0];
      end
      rdThreadOut_ff <= rdThread_ff;
      rdRegOut_ff <= rdReg_ff;
      // the mask only stops threads once debug mode is left
      threadHold_ff <= dbgMode ? 8'h00 : holdMask_ff;
    end
  end

  // read mux; unmapped numbers and reserved bits read zero
  always @*
  begin
    nxt_rdData = 32'h00000000;
    case (psAddr)
      `PSD_REG_OSC_CTRL:
      begin
        nxt_rdData = {30'h00000000, oscCtrl_ff};
      end
      `PSD_REG_OSC_CNT0:
      begin
        nxt_rdData = {16'h0000, oscCount[15:0]};
      end
      `PSD_REG_OSC_CNT1:
      begin
        nxt_rdData = {16'h0000, oscCount[31:16]};
      end
      `PSD_REG_OSC_CNT2:
      begin
        nxt_rdData = {16'h0000, oscCount[47:32]};
      end
      `PSD_REG_OSC_CNT3:
      begin
        nxt_rdData = {16'h0000, oscCount[63:48]};
      end
      `PSD_REG_MEM_SIZE:
      begin
        nxt_rdData = `PSD_MEM_SIZE_BYTES & 32'hfffffffc;
      end
      `PSD_REG_SV_STATUS:
      begin
        nxt_rdData = {21'h000000, svStatus_ff};
      end
      `PSD_REG_SV_PC:
      begin
        nxt_rdData = svPc_ff;
      end
      `PSD_REG_SV_SP:
      begin
        nxt_rdData = svSp_ff;
      end
      `PSD_REG_RD_THREAD:
      begin
        nxt_rdData = {24'h000000, rdThread_ff};
      end
      `PSD_REG_RD_REG:
      begin
        nxt_rdData = {27'h0000000, rdReg_ff};
      end
      `PSD_REG_CAUSE:
      begin
        nxt_rdData = {14'h0000, causeBp_ff, causeThread_ff, 5'h00, causeCode_ff};
      end
      `PSD_REG_INFO:
      begin
        nxt_rdData = info_ff;
      end
      `PSD_REG_HOLD:
      begin
        nxt_rdData = {24'h000000, holdMask_ff};
      end
      default:
      begin
        nxt_rdData = 32'h00000000;
      end
    endcase
  end

  // counts are sampled live; software must stop the oscillator first
  // so the value is not caught mid-increment
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      psRdData_ff <= 32'h00000000;
      psRdValid_ff <= 1'b0;
    end
    else
    begin
      psRdValid_ff <= psRdEn;
      if (psRdEn)
      begin
        psRdData_ff <= nxt_rdData;
      end
    end
  end

endmodule

// File: dv/psd_regs_properties.sv
// port assertions for the processor-status register bank
// assumes sys_clk with async active-low rstn; bound onto every psd_regs
`timescale 1ns/1ps
`include "psd_consts.vh"
module psd_regs_props
(
  input wire sys_clk,
  input wire rstn,
  input wire psWrEn,
  input wire psRdEn,
  input wire [7:0] psAddr,
  input wire [31:0] psWrData,
  input wire dbgMode,
  input wire [31:0] psRdData_ff,
  input wire oscCoreEn_ff,
  input wire oscPeriphEn_ff,
  input wire [7:0] rdThreadOut_ff,
  input wire [7:0] threadHold_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_ctrl_bits: assert property (psWrEn && psAddr == 8'h06 |=> ##1
    oscCoreEn_ff == $past(psWrData[1], 2) && oscPeriphEn_ff == $past(psWrData[0], 2))
    else $error("oscillator enables do not follow control write");
  a_ctrl_rsvd: assert property (psRdEn && psAddr == 8'h06 |=>
    psRdData_ff[31:2] == 30'h0) else $error("control reserved bits not zero");
  a_cnt_upper: assert property (psRdEn && psAddr inside {[8'h07:8'h0a]} |=>
    psRdData_ff[31:16] == 16'h0) else $error("count upper half not zero");
  a_mem_size: assert property (psRdEn && psAddr == 8'h0c |=>
    psRdData_ff == `PSD_MEM_SIZE_BYTES) else $error("memory size wrong");
  a_status_rsvd: assert property (psRdEn && psAddr == 8'h10 |=>
    psRdData_ff[31:11] == 21'h0 && !psRdData_ff[5]) else $error("status reserved set");
  a_thread_op: assert property (psWrEn && dbgMode && psAddr == 8'h13 |=> ##1
    rdThreadOut_ff == $past(psWrData[7:0], 2)) else $error("thread operand wrong");
  a_hold_debug: assert property (dbgMode |=> threadHold_ff == 8'h00)
    else $error("threads held while debugging");
  a_cause_rsvd: assert property (psRdEn && psAddr == 8'h15 |=>
    psRdData_ff[31:18] == 14'h0 && psRdData_ff[7:3] == 5'h0)
    else $error("cause reserved bits set");
endmodule
bind psd_regs psd_regs_props u_props (.sys_clk, .rstn, .psWrEn, .psRdEn, .psAddr,
  .psWrData, .dbgMode, .psRdData_ff, .oscCoreEn_ff, .oscPeriphEn_ff, .rdThreadOut_ff,
  .threadHold_ff);

// File: dv/psd_osc_model.sv
// four ring oscillator outputs that pulse while oscRun is high; a last pulse can still rise up to 13 ns after it falls
// assumes the bench stops them before reading counts
`timescale 1ns/1ps
module psd_osc_model
(
  input wire oscRun,
  output reg [3:0] oscOut,
  output reg [15:0] riseCnt
);
  initial
  begin
    oscOut = 4'h0;
    riseCnt = 16'h0;
  end
  // 13 ns phases drift against the 4 ns core clock
  always
  begin
    wait (oscRun);
    #13;
    oscOut = 4'hf;
    riseCnt = riseCnt + 16'h1;
    #13;
    oscOut = 4'h0;
  end
endmodule

// File: dv/test_processor_status_debug_regs.sv
// self-checking bench for the processor-status register bank
// assumes the oscillator model stands in for the ring oscillators
`timescale 1ns/1ps
`include "psd_consts.vh"
module test_processor_status_debug_regs;
  reg sys_clk = 1'h0, rstn = 1'h0, porRstn = 1'h0, psWrEn = 1'h0, psRdEn = 1'h0;
  reg dbgMode = 1'h0, dbgEntry = 1'h0, oscRun = 1'h0;
  reg [7:0] psAddr = 8'h0, entryThread = 8'h5a;
  reg [31:0] psWrData = 32'h0, entryPc = 32'h80001234, entrySp = 32'h0007fff0;
  reg [31:0] entryInfo = 32'h0, e;
  reg [10:0] entryStatus = 11'h7ff;
  reg [2:0] entryCause = 3'h0;
  reg [3:0] entryHits = 4'h0;
  wire [3:0] oscIn;
  wire [15:0] riseCnt;
  wire [31:0] psRdData_ff;
  wire psRdValid_ff, oscCoreEn_ff, oscPeriphEn_ff;
  wire [7:0] rdThreadOut_ff, threadHold_ff;
  wire [4:0] rdRegOut_ff;
  integer err_total = 0, num_checks = 0, i;
  always #2 sys_clk = ~sys_clk;
  psd_regs u_dut (.sys_clk, .rstn, .porRstn, .psWrEn, .psRdEn, .psAddr, .psWrData,
    .dbgMode, .oscIn, .dbgEntry, .entryStatus, .entryPc, .entrySp, .entryCause,
    .entryThread, .entryHits, .entryInfo, .psRdData_ff, .psRdValid_ff, .oscCoreEn_ff,
    .oscPeriphEn_ff, .rdThreadOut_ff, .rdRegOut_ff, .threadHold_ff);
  psd_osc_model u_osc (.oscRun, .oscOut(oscIn), .riseCnt);
  task chk(input [31:0] got, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(negedge sys_clk);
    psWrEn = 1'h1;
    psAddr = a;
    psWrData = d;
    @(negedge sys_clk);
    psWrEn = 1'h0;
  end
  endtask
  task rd(input [7:0] a, input [31:0] x);
  begin
    @(negedge sys_clk);
    psRdEn = 1'h1;
    psAddr = a;
    @(negedge sys_clk);
    psRdEn = 1'h0;
    chk({31'h0, psRdValid_ff}, 32'h1);
    chk(psRdData_ff, x);
  end
  endtask
  task t_ctrl;
  begin
    rd(8'h06, 32'h0);
    wr(8'h06, 32'hffffffff);
    rd(8'h06, 32'h3);
    chk({oscCoreEn_ff, oscPeriphEn_ff}, 32'h3);
    wr(8'h0c, 32'h0);
    rd(8'h0c, `PSD_MEM_SIZE_BYTES);
    rd(8'h0b, 32'h0);
    wr(8'h06, 32'h0);
    $display("t_ctrl done");
  end
  endtask
  task t_dbg;
  begin
    dbgMode = 1'h1;
    wr(8'h10, 32'hffffffff);
    wr(8'h13, 32'hffffffff);
    wr(8'h14, 32'hffffffff);
    wr(8'h15, 32'hffffffff);
    wr(8'h18, 32'h4);
    rd(8'h10, 32'h6df);
    rd(8'h13, 32'hff);
    rd(8'h14, 32'h1f);
    rd(8'h15, 32'h0003ff07);
    rd(8'h18, 32'h4);
    chk({rdThreadOut_ff, 3'h0, rdRegOut_ff}, 32'hff1f);
    chk(threadHold_ff, 32'h0);
    dbgMode = 1'h0;
    wr(8'h13, 32'h0);
    rd(8'h13, 32'hff);
    chk(threadHold_ff, 32'h4);
    $display("t_dbg done");
  end
  endtask
  task t_entry;
  begin
    for (i = 1; i < 6; i = i + 1)
    begin
      @(negedge sys_clk);
      dbgEntry = 1'h1;
      entryCause = i[2:0];
      entryHits = (i < 3) ? 4'hf : 4'h8 | (4'h1 << (i - 2));
      entryInfo = 32'h1234ab00 + i[31:0];
      @(negedge sys_clk);
      dbgEntry = 1'h0;
      e = {14'h0, (i < 3) ? 2'h0 : i[1:0] - 2'h2, (i == 1) ? 8'h0 : 8'h5a, 5'h0, i[2:0]};
      rd(8'h15, e);
      rd(8'h16, (i > 3) ? entryInfo : 32'h0);
    end
    rd(8'h10, 32'h7df);
    rd(8'h11, entryPc);
    rd(8'h12, entrySp);
    $display("t_entry done");
  end
  endtask
  task t_osc;
  begin
    wr(8'h06, 32'h2);
    oscRun = 1'h1;
    repeat (300) @(negedge sys_clk);
    oscRun = 1'h0;
    repeat (16) @(negedge sys_clk);
    wr(8'h06, 32'h0);
    repeat (10) @(negedge sys_clk);
    rd(8'h07, {16'h0, riseCnt});
    rd(8'h08, {16'h0, riseCnt});
    rd(8'h09, 32'h0);
    rd(8'h0a, 32'h0);
    e = {16'h0, riseCnt};
    wr(8'h06, 32'h1);
    oscRun = 1'h1;
    repeat (300) @(negedge sys_clk);
    oscRun = 1'h0;
    repeat (16) @(negedge sys_clk);
    wr(8'h06, 32'h0);
    repeat (10) @(negedge sys_clk);
    rd(8'h07, e);
    rd(8'h08, e);
    rd(8'h09, {16'h0, riseCnt - e[15:0]});
    rd(8'h0a, {16'h0, riseCnt - e[15:0]});
    rstn = 1'h0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'h1;
    rd(8'h07, e);
    rd(8'h09, {16'h0, riseCnt - e[15:0]});
    rd(8'h06, 32'h0);
    rd(8'h15, 32'h0);
    $display("t_osc done");
  end
  endtask
  task final_report;
  begin
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #200000;
    err_total = err_total + 1;
    final_report;
  end
  initial
  begin
    repeat (10) @(negedge sys_clk);
    rstn = 1'h1;
    porRstn = 1'h1;
    t_ctrl;
    t_dbg;
    t_entry;
    t_osc;
    final_report;
  end
endmodule
